// >>> rtl/pc_stack_params.svh
// Constants for the program counter, return stack and indirect addressing block.
`ifndef PC_STACK_PARAMS_SVH
`define PC_STACK_PARAMS_SVH

`define PC_WIDTH        13
`define PC_HIGH_WIDTH   5
`define STACK_DEPTH     8
`define STACK_PTR_WIDTH 3
`define OPERAND_WIDTH   11
`define LATCH_PAGE_HI   4
`define LATCH_PAGE_LO   3
`define PC_RESET        13'h0000
`define LATCH_RESET     5'h00
`define PTR_RESET       3'h0
`define FILE_ADDR_WIDTH 7
`define INDIRECT_ADDR_W 9
`define INDIRECT_PORT   7'h00

`endif

// >>> rtl/pc_stack_pkg.sv
// Types shared by the program counter, return stack and indirect addressing block.
package pc_stack_pkg;

	typedef enum logic [6:0] {
		OP_NONE      = 7'h01,
		OP_CALL      = 7'h02,
		OP_JUMP      = 7'h04,
		OP_RETURN    = 7'h08,
		OP_RET_LIT   = 7'h10,
		OP_RET_INT   = 7'h20,
		OP_INT_ENTRY = 7'h40
	} flow_op_t;

	typedef struct packed {
		logic [6:0] file_addr;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} file_req_t;

	typedef struct packed {
		logic [8:0] addr;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} mem_req_t;

endpackage

// >>> rtl/pc_stack_indirect_addr.sv
// Program counter, circular return stack and indirect data addressing.
//
// Summary of operation
// - Low-byte write loads upper bits from latch.
// - PC becomes latch bits above written byte.
// - Call loads operand, top two from latch.
// - Eight-entry, thirteen-bit hardware return stack.
// - Stack pointer is never software reachable.
// - Push PC plus one on call and interrupt entry.
// - Pop into PC on all three returns.
// - Push and pop leave latch unchanged.
// - Stack is circular; ninth push overwrites first.
// - No overflow or underflow flags exist.
// - Indirect port redirects to pointer-addressed location.
// - Indirect read of indirect port returns zero.
// - Indirect write to indirect port stores nothing.
// - Indirect address is bank bit over pointer.
// - Every reset clears the program counter.
// - Jump loads PC like a call.
`timescale 1ns/1ps
`include "pc_stack_params.svh"

module pc_stack_indirect_addr #(
	parameter int DEPTH    = `STACK_DEPTH,
	parameter int PTR_W    = `STACK_PTR_WIDTH
) (
	// Clock, reset and enable
	input  wire logic                           mclk_i,
	input  wire logic                           arst_n_i,
	input  wire logic                           ce_i,
	// Instruction flow from the decoder
	input  wire pc_stack_pkg::flow_op_t         flow_op_i,
	input  wire logic [`OPERAND_WIDTH-1:0]      operand_i,
	input  wire logic                           step_i,
	input  wire logic                           pc_low_wr_i,
	input  wire logic [7:0]                     pc_low_wdata_i,
	input  wire logic                           latch_wr_i,
	input  wire logic [`PC_HIGH_WIDTH-1:0]      latch_wdata_i,
	// Data access from the decoder
	input  wire pc_stack_pkg::file_req_t        file_req_i,
	input  wire logic [7:0]                     file_select_pointer_i,
	input  wire logic                           indirect_bank_bit_i,
	input  wire logic [7:0]                     mem_rdata_i,
	// Program flow state
	output logic [`PC_WIDTH-1:0]                pc_o,
	output logic [`PC_HIGH_WIDTH-1:0]           pc_high_latch_o,
	// Data memory side
	output pc_stack_pkg::mem_req_t              mem_req_o,
	output logic [7:0]                          file_rdata_o
);

	// ----------------------------------------------------------------
	// Program counter and return stack
	// ----------------------------------------------------------------

	logic [`PC_WIDTH-1:0]      pc;
	logic [`PC_WIDTH-1:0]      next_pc;
	logic [`PC_HIGH_WIDTH-1:0] pc_high_latch;
	logic [`PC_HIGH_WIDTH-1:0] next_pc_high_latch;
	logic [PTR_W-1:0]          stack_ptr;
	logic [PTR_W-1:0]          next_stack_ptr;
	logic [`PC_WIDTH-1:0]      stack_mem [DEPTH];
	logic [`PC_WIDTH-1:0]      page_target;
	logic                      push;
	logic                      pop;
	logic [`PC_WIDTH-1:0]      return_pc;

	// The pointer lives only here and drives no port, so software never sees it.
	assign push        = (flow_op_i == pc_stack_pkg::OP_CALL) ||
	                     (flow_op_i == pc_stack_pkg::OP_INT_ENTRY);
	assign pop         = (flow_op_i == pc_stack_pkg::OP_RETURN) ||
	                     (flow_op_i == pc_stack_pkg::OP_RET_LIT) ||
	                     (flow_op_i == pc_stack_pkg::OP_RET_INT);
	assign page_target = {pc_high_latch[`LATCH_PAGE_HI:`LATCH_PAGE_LO], operand_i};
	assign return_pc   = pc + `PC_WIDTH'(1);

	always_comb begin
		next_pc            = pc;
		next_pc_high_latch = pc_high_latch;
		next_stack_ptr     = stack_ptr;
		if (latch_wr_i) begin
			next_pc_high_latch = latch_wdata_i;
		end
		case (flow_op_i)
			pc_stack_pkg::OP_CALL: begin
				next_pc        = page_target;
				next_stack_ptr = stack_ptr + PTR_W'(1);
			end
			pc_stack_pkg::OP_INT_ENTRY: begin
				next_pc        = `PC_WIDTH'(operand_i);
				next_stack_ptr = stack_ptr + PTR_W'(1);
			end
			pc_stack_pkg::OP_JUMP: begin
				next_pc = page_target;
			end
			pc_stack_pkg::OP_RETURN, pc_stack_pkg::OP_RET_LIT,
			pc_stack_pkg::OP_RET_INT: begin
				next_pc        = stack_mem[stack_ptr - PTR_W'(1)];
				next_stack_ptr = stack_ptr - PTR_W'(1);
			end
			pc_stack_pkg::OP_NONE: begin
				if (pc_low_wr_i) begin
					next_pc = {pc_high_latch, pc_low_wdata_i};
				end else if (step_i) begin
					next_pc = return_pc;
				end
			end
			default: begin
				next_pc = pc;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pc            <= `PC_RESET;
			pc_high_latch <= `LATCH_RESET;
			stack_ptr     <= `PTR_RESET;
		end else if (ce_i) begin
			pc            <= next_pc;
			pc_high_latch <= next_pc_high_latch;
			stack_ptr     <= next_stack_ptr;
		end
	end

	// The stack array has no reset; an early pop returns whatever the slot holds.
	always_ff @(posedge mclk_i) begin
		if (ce_i && push) begin
			stack_mem[stack_ptr] <= return_pc;
		end
	end

	assign pc_o            = pc;
	assign pc_high_latch_o = pc_high_latch;

	// ----------------------------------------------------------------
	// Indirect data addressing
	// ----------------------------------------------------------------

	pc_stack_pkg::mem_req_t mem_req;
	pc_stack_pkg::mem_req_t next_mem_req;
	logic                   via_port;
	logic                   self_ref;
	logic                   self_ref_q;
	logic [7:0]             file_rdata;

	assign via_port = file_req_i.file_addr == `INDIRECT_PORT;
	assign self_ref = via_port && (file_select_pointer_i[6:0] == `INDIRECT_PORT);

	always_comb begin
		next_mem_req       = '0;
		next_mem_req.rd    = file_req_i.rd;
		next_mem_req.wr    = file_req_i.wr;
		next_mem_req.wdata = file_req_i.wdata;
		if (via_port) begin
			next_mem_req.addr = {indirect_bank_bit_i, file_select_pointer_i};
		end else begin
			next_mem_req.addr = {2'h0, file_req_i.file_addr};
		end
		if (self_ref) begin
			next_mem_req.rd = 1'b0;
			next_mem_req.wr = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mem_req    <= '0;
			self_ref_q <= 1'b0;
			file_rdata <= 8'h00;
		end else if (ce_i) begin
			mem_req    <= next_mem_req;
			self_ref_q <= self_ref && file_req_i.rd;
			file_rdata <= self_ref_q ? 8'h00 : mem_rdata_i;
		end
	end

	assign mem_req_o    = mem_req;
	assign file_rdata_o = file_rdata;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	property p_low_write;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && flow_op_i == pc_stack_pkg::OP_NONE && pc_low_wr_i && !latch_wr_i)
		|=> pc_o == {$past(pc_high_latch), $past(pc_low_wdata_i)};
	endproperty
	a_low_write: assert property (p_low_write) else $error("pc low write wrong");

	property p_call_target;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && flow_op_i == pc_stack_pkg::OP_CALL)
		|=> pc_o == {$past(pc_high_latch[4:3]), $past(operand_i)};
	endproperty
	a_call_target: assert property (p_call_target) else $error("call target wrong");

	property p_jump_target;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && flow_op_i == pc_stack_pkg::OP_JUMP)
		|=> pc_o == {$past(pc_high_latch[4:3]), $past(operand_i)};
	endproperty
	a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

	property p_call_return;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && flow_op_i == pc_stack_pkg::OP_CALL) ##1
		(ce_i && flow_op_i == pc_stack_pkg::OP_RETURN)
		|=> pc_o == $past(pc_o, 2) + 13'h0001;
	endproperty
	a_call_return: assert property (p_call_return) else $error("return address wrong");

	property p_latch_kept;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && (push || pop) && !latch_wr_i) |=> $stable(pc_high_latch_o);
	endproperty
	a_latch_kept: assert property (p_latch_kept) else $error("latch changed");

	property p_ptr_wrap;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && push) |=> stack_ptr == $past(stack_ptr) + 3'h1;
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap) else $error("push pointer wrong");

	property p_pop_wrap;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && pop) |=> stack_ptr == $past(stack_ptr) - 3'h1;
	endproperty
	a_pop_wrap: assert property (p_pop_wrap) else $error("pop pointer wrong");

	property p_indirect_addr;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && via_port && !self_ref)
		|=> mem_req_o.addr == {$past(indirect_bank_bit_i), $past(file_select_pointer_i)};
	endproperty
	a_indirect_addr: assert property (p_indirect_addr) else $error("indirect addr wrong");

	property p_self_write;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && self_ref) |=> !mem_req_o.wr && !mem_req_o.rd;
	endproperty
	a_self_write: assert property (p_self_write) else $error("self access stored");

	property p_self_read;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && self_ref && file_req_i.rd) ##1 ce_i |=> file_rdata_o == 8'h00;
	endproperty
	a_self_read: assert property (p_self_read) else $error("self read not zero");

	property p_reset_clear;
		@(posedge mclk_i)
		!arst_n_i |-> pc_o == `PC_RESET && stack_ptr == `PTR_RESET;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left pc set");

	property p_push_value;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && push) |=> stack_mem[stack_ptr - 3'h1] == $past(pc_o) + 13'h0001;
	endproperty
	a_push_value: assert property (p_push_value) else $error("pushed address wrong");

	property p_pop_value;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && pop) |=> pc_o == $past(stack_mem[stack_ptr - 3'h1]);
	endproperty
	a_pop_value: assert property (p_pop_value) else $error("popped address wrong");

	property p_int_vector;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && flow_op_i == pc_stack_pkg::OP_INT_ENTRY)
		|=> pc_o == {2'h0, $past(operand_i)};
	endproperty
	a_int_vector: assert property (p_int_vector) else $error("vector load wrong");

	property p_step;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && flow_op_i == pc_stack_pkg::OP_NONE && !pc_low_wr_i && step_i)
		|=> pc_o == $past(pc_o) + 13'h0001;
	endproperty
	a_step: assert property (p_step) else $error("pc step wrong");

	property p_latch_write;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && latch_wr_i) |=> pc_high_latch_o == $past(latch_wdata_i);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("latch write lost");

	property p_ptr_hold;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && !push && !pop) |=> $stable(stack_ptr);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");

	property p_freeze;
		@(posedge mclk_i) disable iff (!arst_n_i)
		!ce_i |=> $stable(pc_o) && $stable(pc_high_latch_o) && $stable(stack_ptr) &&
		$stable(mem_req_o) && $stable(file_rdata_o);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	property p_port_pass;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && via_port && !self_ref)
		|=> mem_req_o.rd == $past(file_req_i.rd) && mem_req_o.wr == $past(file_req_i.wr) &&
		mem_req_o.wdata == $past(file_req_i.wdata);
	endproperty
	a_port_pass: assert property (p_port_pass) else $error("indirect access lost");

	property p_direct_pass;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && !via_port)
		|=> mem_req_o.addr == {2'h0, $past(file_req_i.file_addr)} &&
		mem_req_o.rd == $past(file_req_i.rd) && mem_req_o.wr == $past(file_req_i.wr);
	endproperty
	a_direct_pass: assert property (p_direct_pass) else $error("direct access wrong");

	property p_read_data;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(ce_i && !self_ref_q) |=> file_rdata_o == $past(mem_rdata_i);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data lost");

endmodule // pc_stack_indirect_addr

// >>> testbench/test_pc_stack_indirect_addr.sv
// Self-checking bench for the program counter, return stack and indirect addressing block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
	end \
end

module test_pc_stack_indirect_addr;
	typedef struct {int due; int kind; logic [31:0] v;} note_t;
	// ----------------------------------------
	// Ports and reference model state
	// ----------------------------------------
	logic                    mclk_i = 1'b0;
	logic                    arst_n_i = 1'b1;
	logic                    ce_i = 1'b1;
	pc_stack_pkg::flow_op_t  flow_op_i = pc_stack_pkg::OP_NONE;
	logic [10:0]             operand_i = 11'h000;
	logic                    step_i = 1'b0;
	logic                    pc_low_wr_i = 1'b0;
	logic [7:0]              pc_low_wdata_i = 8'h00;
	logic                    latch_wr_i = 1'b0;
	logic [4:0]              latch_wdata_i = 5'h00;
	pc_stack_pkg::file_req_t file_req_i = '0;
	logic [7:0]              file_select_pointer_i = 8'h00;
	logic                    indirect_bank_bit_i = 1'b0;
	logic [7:0]              mem_rdata_i = 8'h00;
	logic [12:0]             pc_o;
	logic [4:0]              pc_high_latch_o;
	pc_stack_pkg::mem_req_t  mem_req_o;
	logic [7:0]              file_rdata_o;
	logic [12:0]             m_pc = 13'h0000;
	logic [12:0]             stk [8];
	logic [4:0]              m_lat = 5'h00;
	logic [2:0]              sp = 3'h0;
	pc_stack_pkg::file_req_t req_n = '0;
	logic [7:0]              fsr_n = 8'h00;
	logic [7:0]              mrd_n = 8'h00;
	logic                    bank_n = 1'b0;
	logic                    ce_n = 1'b1;
	logic [31:0]             rv;
	logic [31:0]             rw;
	int                      seed = 39137;
	int                      cnt = 0;
	int                      bad_count = 0;
	int                      comparisons = 0;
	note_t                   notes [$];
	note_t                   n;
	// Order: none, call, jump, return, return with literal, return from interrupt, entry.
	pc_stack_pkg::flow_op_t  ops [7] = '{pc_stack_pkg::OP_NONE, pc_stack_pkg::OP_CALL,
		pc_stack_pkg::OP_JUMP, pc_stack_pkg::OP_RETURN, pc_stack_pkg::OP_RET_LIT,
		pc_stack_pkg::OP_RET_INT, pc_stack_pkg::OP_INT_ENTRY};

	pc_stack_indirect_addr pc_stack_indirect_addr_inst (.mclk_i, .arst_n_i, .ce_i, .flow_op_i,
		.operand_i, .step_i, .pc_low_wr_i, .pc_low_wdata_i, .latch_wr_i, .latch_wdata_i,
		.file_req_i, .file_select_pointer_i, .indirect_bank_bit_i, .mem_rdata_i, .pc_o,
		.pc_high_latch_o, .mem_req_o, .file_rdata_o);

	always #4 mclk_i = ~mclk_i;

	task automatic put(input int d, input int k, input logic [31:0] v);
		notes.push_back('{d, k, v});
	endtask

	// ----------------------------------------
	// One instruction cycle with its notes
	// ----------------------------------------
	// Notes are queued in order of due cycle, so the watcher never stalls on a later one.
	task automatic cyc(input pc_stack_pkg::flow_op_t op, input logic [10:0] opd, input logic lw,
		input logic [7:0] lb, input logic hw, input logic [4:0] hb, input logic st);
		logic self;
		@(posedge mclk_i);
		ce_i <= ce_n;
		flow_op_i <= op;
		operand_i <= opd;
		step_i <= st;
		pc_low_wr_i <= lw;
		pc_low_wdata_i <= lb;
		latch_wr_i <= hw;
		latch_wdata_i <= hb;
		file_req_i <= req_n;
		file_select_pointer_i <= fsr_n;
		indirect_bank_bit_i <= bank_n;
		mem_rdata_i <= mrd_n;
		if (ce_n) begin
			case (op)
				pc_stack_pkg::OP_CALL, pc_stack_pkg::OP_INT_ENTRY: begin
					stk[sp] = m_pc + 13'h1;
					sp = sp + 3'h1;
					m_pc = (op == pc_stack_pkg::OP_CALL) ? {m_lat[4:3], opd} : {2'h0, opd};
				end
				pc_stack_pkg::OP_JUMP: m_pc = {m_lat[4:3], opd};
				pc_stack_pkg::OP_NONE: m_pc = lw ? {m_lat, lb} : (st ? m_pc + 13'h1 : m_pc);
				default: begin
					sp = sp - 3'h1;
					m_pc = stk[sp];
				end
			endcase
			if (hw) m_lat = hb;
		end
		put(cnt + 2, 0, {19'h0, m_pc});
		put(cnt + 2, 1, {27'h0, m_lat});
		self = req_n.file_addr == 7'h00 && fsr_n[6:0] == 7'h00;
		rv = $random(seed);
		mrd_n = rv[7:0];
		if (ce_n && self) begin
			put(cnt + 2, 3, 32'h0);
		end else if (ce_n && req_n.file_addr == 7'h00) begin
			put(cnt + 2, 2, {13'h0, bank_n, fsr_n, req_n.rd, req_n.wr, req_n.wdata});
		end else if (ce_n) begin
			put(cnt + 2, 2, {15'h0, req_n.file_addr, req_n.rd, req_n.wr, req_n.wdata});
		end
		if (ce_n && req_n.rd) put(cnt + 3, 4, {24'h0, self ? 8'h00 : mrd_n});
		req_n = '0;
	endtask

	// ----------------------------------------
	// Watcher and verdict
	// ----------------------------------------
	always @(negedge mclk_i) begin
		cnt = cnt + 1;
		while (notes.size() > 0 && notes[0].due <= cnt) begin
			n = notes.pop_front();
			case (n.kind)
				0: `CHK("pc_o", n.v[12:0], pc_o)
				1: `CHK("pc_high_latch_o", n.v[4:0], pc_high_latch_o)
				2: `CHK("mem_req_o", n.v[18:0], mem_req_o)
				3: `CHK("mem_req_o rd wr", n.v[1:0], {mem_req_o.rd, mem_req_o.wr})
				default: `CHK("file_rdata_o", n.v[7:0], file_rdata_o)
			endcase
		end
	end

	task automatic summarize();
		if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		// A declared start value raises no edge, so reset is driven low here.
		arst_n_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		cyc(ops[0], 11'h000, 0, 8'h00, 0, 5'h00, 0);
		cyc(ops[0], 11'h000, 0, 8'h00, 1, 5'h1A, 0);
		cyc(ops[0], 11'h000, 1, 8'h3C, 0, 5'h00, 0);
		cyc(ops[0], 11'h000, 1, 8'hC5, 1, 5'h07, 0);
		cyc(ops[1], 11'h2A5, 1, 8'hFF, 0, 5'h00, 0);
		cyc(ops[0], 11'h000, 0, 8'h00, 1, 5'h18, 1);
		cyc(ops[2], 11'h7FF, 0, 8'h00, 0, 5'h00, 0);
		cyc(ops[6], 11'h004, 0, 8'h00, 0, 5'h00, 0);
		cyc(ops[5], 11'h000, 0, 8'h00, 0, 5'h00, 0);
		ce_n = 1'b0;
		cyc(ops[1], 11'h123, 0, 8'h00, 1, 5'h0F, 0);
		ce_n = 1'b1;
		for (int i = 0; i < 9; i++) cyc(ops[1], 11'h100 + i, 0, 8'h00, 0, 5'h00, 0);
		for (int i = 0; i < 10; i++) cyc(ops[3 + i % 3], 11'h0, 0, 8'h0, 0, 5'h0, 0);
		for (int i = 0; i < 60; i++) begin
			rw = $random(seed);
			req_n.file_addr = rw[10] ? 7'h00 : rw[30:24];
			req_n.rd = rw[9];
			req_n.wr = ~rw[9];
			req_n.wdata = rw[23:16];
			fsr_n = {rw[7], rw[15] ? 7'h00 : rw[6:0]};
			bank_n = rw[8];
			rv = $random(seed);
			cyc(ops[rv[31:16] % 7], rv[10:0], rv[11], rv[7:0], rv[12], rv[4:0], rv[13]);
		end
		cyc(ops[0], 11'h000, 0, 8'h00, 0, 5'h00, 0);
		for (int i = 0; i < 6 && notes.size() > 0; i++) @(posedge mclk_i);
		if (notes.size() > 0) bad_count++;
		arst_n_i <= 1'b0;
		m_pc = 13'h0000;
		m_lat = 5'h00;
		sp = 3'h0;
		repeat (3) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		cyc(ops[0], 11'h000, 0, 8'h00, 0, 5'h00, 0);
		cyc(ops[3], 11'h000, 0, 8'h00, 0, 5'h00, 0);
		cyc(ops[0], 11'h000, 0, 8'h00, 0, 5'h00, 0);
		for (int i = 0; i < 6 && notes.size() > 0; i++) @(posedge mclk_i);
		if (notes.size() > 0) bad_count++;
		summarize();
	end
endmodule // test_pc_stack_indirect_addr
